// >>> rtl/pwt_pkg.sv
// register map, field layout, reset values and bus states of the pwm timer
package pwt_pkg;

    // byte address width on the register bus
    localparam int ADDR_W = 18;

    // register indices, byte address is four times the index
    localparam logic [15:0] IDX_CMP_A = 16'h5300;
    localparam logic [15:0] IDX_CMP_B = 16'h5302;
    localparam logic [15:0] IDX_COUNT = 16'h5304;
    localparam logic [15:0] IDX_CTRL = 16'h5306;
    localparam logic [15:0] IDX_CLK_SEL = 16'h5308;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h530a;
    localparam logic [15:0] IDX_IRQ_FLAG = 16'h530c;

    // control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;

    // interrupt mask and flag fields, same layout in both
    localparam int IRQ_A_BIT = 0;
    localparam int IRQ_B_BIT = 1;

    // prescaler tap select
    localparam int TAP_W = 4;
    localparam logic [3:0] TAP_RESERVED = 4'hf;
    localparam int PSC_W = 14;

    // values after reset
    localparam logic [3:0] TAP_RST = 4'h0;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic RUN_RST = 1'b0;

    // register bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } pwt_bus_t;

endpackage

// >>> rtl/pwt_prescaler.sv
// prescaler with a selectable power-of-two tap for the timer count clock
`timescale 1ns/10ps
module pwt_prescaler (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] tap_sel,
    output logic tick
);

    typedef struct packed {
        logic [13:0] div;
        logic tick;
    } pwt_psc_state_t;

    pwt_psc_state_t st;
    pwt_psc_state_t nx;

    // low bits that must all be ones for a tap of 2 to the n
    function automatic logic [13:0] tap_mask(input logic [3:0] sel);
        tap_mask = (14'h1 << sel) - 14'h1;
    endfunction

    // free-running divider, one tick every 2 to the n clocks, none when reserved
    always_comb begin
        nx = st;
        nx.div = st.div + 14'h1;
        nx.tick = (tap_sel != pwt_pkg::TAP_RESERVED) &&
                  (&(st.div | ~tap_mask(tap_sel)));
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '{div: 14'h0, tick: 1'b0};
        end else begin
            st <= nx;
        end
    end

    assign tick = st.tick;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_tap_reserved: assert property (
        tap_sel == pwt_pkg::TAP_RESERVED |=> !st.tick)
        else $error("tick produced on reserved tap");
    a_tap_full: assert property (
        !sys_rst && tap_sel == 4'h0 |=> st.tick)
        else $error("undivided tap missed a tick");
    a_tap_half: assert property (
        tap_sel == 4'h1 && $stable(tap_sel) && st.tick |=> !st.tick)
        else $error("divide by two tap ticked twice in a row");

endmodule

// >>> rtl/pwt_timer.sv
// pwm timer counter, compare events, clock select and interrupt registers
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
module pwt_timer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic pwm_out,
    output logic cmp_a_evt,
    output logic cmp_b_evt
);

    // complete state of the block
    typedef struct packed {
        pwt_pkg::pwt_bus_t bus;
        logic wait_rq;
        logic [31:0] rdata;
        logic run;
        logic [3:0] tap;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] count;
        logic [1:0] msk;
        logic [1:0] flg;
        logic irq;
        logic pwm;
        logic evt_a;
        logic evt_b;
    } pwt_state_t;

    localparam pwt_state_t ST_RST = '{
        bus: pwt_pkg::BUS_IDLE,
        wait_rq: 1'b1,
        rdata: 32'h0000_0000,
        run: pwt_pkg::RUN_RST,
        tap: pwt_pkg::TAP_RST,
        cmp_a: pwt_pkg::CMP_RST,
        cmp_b: pwt_pkg::CMP_RST,
        count: pwt_pkg::COUNT_RST,
        msk: pwt_pkg::IRQ_RST,
        flg: pwt_pkg::IRQ_RST,
        irq: 1'b0,
        pwm: 1'b0,
        evt_a: 1'b0,
        evt_b: 1'b0
    };

    pwt_state_t st;
    pwt_state_t nx;

    logic tick;
    logic req;
    logic wr_go;
    logic wr_cmp_a;
    logic wr_cmp_b;
    logic wr_count;
    logic wr_ctrl;
    logic wr_tap;
    logic wr_mask;
    logic wr_flag;
    logic wr_clr;
    logic [1:0] clr;
    logic step;
    logic hit_a;
    logic hit_b;
    logic ev_a;
    logic ev_b;

    // true when the byte address selects the register of this index
    function automatic logic reg_hit(
        input logic [17:0] addr,
        input logic [15:0] idx
    );
        reg_hit = (addr == {idx, 2'b00});
    endfunction

    // merge a 16-bit register with written bytes under the byte enables
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] be
    );
        merge16[7:0] = be[0] ? data[7:0] : old[7:0];
        merge16[15:8] = be[1] ? data[15:8] : old[15:8];
    endfunction

    // count clock from the selected prescaler tap
    pwt_prescaler u_psc (
        .clk(clk),
        .sys_rst(sys_rst),
        .tap_sel(st.tap),
        .tick(tick)
    );

    // a write lands at the edge where waitrequest is seen low
    assign req = avs_read | avs_write;
    assign wr_go = avs_write && (st.bus == pwt_pkg::BUS_ACK);
    assign wr_cmp_a = wr_go && reg_hit(avs_address, pwt_pkg::IDX_CMP_A);
    assign wr_cmp_b = wr_go && reg_hit(avs_address, pwt_pkg::IDX_CMP_B);
    assign wr_count = wr_go && reg_hit(avs_address, pwt_pkg::IDX_COUNT);
    assign wr_ctrl = wr_go && reg_hit(avs_address, pwt_pkg::IDX_CTRL);
    assign wr_tap = wr_go && reg_hit(avs_address, pwt_pkg::IDX_CLK_SEL);
    assign wr_mask = wr_go && reg_hit(avs_address, pwt_pkg::IDX_IRQ_MASK);
    assign wr_flag = wr_go && reg_hit(avs_address, pwt_pkg::IDX_IRQ_FLAG);

    // timer reset bit is a strobe, it is never stored
    assign wr_clr = wr_ctrl && avs_byteenable[0] &&
                    avs_writedata[pwt_pkg::CTRL_CLR_BIT];

    // ones written into the flag register clear, zeros do nothing
    assign clr = (wr_flag && avs_byteenable[0]) ? avs_writedata[1:0] : 2'b00;

    // compare events happen on a counting step
    assign step = st.run && tick;
    assign hit_a = (st.count == st.cmp_a);
    assign hit_b = (st.count == st.cmp_b);
    assign ev_a = step && hit_a;
    assign ev_b = step && hit_b;

    // next state of the whole block
    always_comb begin
        nx = st;

        // bus handshake, every request answered one cycle later
        unique case (st.bus)
            pwt_pkg::BUS_IDLE: begin
                nx.wait_rq = 1'b1;
                if (req) begin
                    nx.bus = pwt_pkg::BUS_ACK;
                    nx.wait_rq = 1'b0;
                    nx.rdata = 32'h0000_0000;
                    if (reg_hit(avs_address, pwt_pkg::IDX_CMP_A)) begin
                        nx.rdata[15:0] = st.cmp_a;
                    end else if (reg_hit(avs_address, pwt_pkg::IDX_CMP_B)) begin
                        nx.rdata[15:0] = st.cmp_b;
                    end else if (reg_hit(avs_address, pwt_pkg::IDX_COUNT)) begin
                        nx.rdata[15:0] = st.count;
                    end else if (reg_hit(avs_address, pwt_pkg::IDX_CTRL)) begin
                        nx.rdata[pwt_pkg::CTRL_RUN_BIT] = st.run;
                    end else if (reg_hit(avs_address, pwt_pkg::IDX_CLK_SEL)) begin
                        nx.rdata[3:0] = st.tap;
                    end else if (reg_hit(avs_address, pwt_pkg::IDX_IRQ_MASK)) begin
                        nx.rdata[1:0] = st.msk;
                    end else if (reg_hit(avs_address, pwt_pkg::IDX_IRQ_FLAG)) begin
                        nx.rdata[1:0] = st.flg;
                    end
                end
            end
            pwt_pkg::BUS_ACK: begin
                nx.bus = pwt_pkg::BUS_IDLE;
                nx.wait_rq = 1'b1;
            end
            default: begin
                nx.bus = pwt_pkg::BUS_IDLE;
                nx.wait_rq = 1'b1;
            end
        endcase

        // configuration writes
        if (wr_cmp_a) begin
            nx.cmp_a = merge16(st.cmp_a, avs_writedata, avs_byteenable);
        end
        if (wr_cmp_b) begin
            nx.cmp_b = merge16(st.cmp_b, avs_writedata, avs_byteenable);
        end
        if (wr_ctrl && avs_byteenable[0]) begin
            nx.run = avs_writedata[pwt_pkg::CTRL_RUN_BIT];
        end
        if (wr_tap && avs_byteenable[0]) begin
            nx.tap = avs_writedata[3:0];
        end
        if (wr_mask && avs_byteenable[0]) begin
            nx.msk = avs_writedata[1:0];
        end

        // counter wraps on compare B, holds while stopped
        if (step) begin
            nx.count = ev_b ? pwt_pkg::COUNT_RST : st.count + 16'h1;
        end
        if (wr_count) begin
            nx.count = merge16(st.count, avs_writedata, avs_byteenable);
        end
        if (wr_clr) begin
            nx.count = pwt_pkg::COUNT_RST;
        end

        // output goes high at period start and low at compare A
        if (ev_b) begin
            nx.pwm = 1'b1;
        end
        if (ev_a) begin
            nx.pwm = 1'b0;
        end
        nx.evt_a = ev_a;
        nx.evt_b = ev_b;

        // sticky flags, a new event wins over a clear in the same cycle
        nx.flg[pwt_pkg::IRQ_A_BIT] = (st.flg[pwt_pkg::IRQ_A_BIT] &
                                      ~clr[pwt_pkg::IRQ_A_BIT]) | ev_a;
        nx.flg[pwt_pkg::IRQ_B_BIT] = (st.flg[pwt_pkg::IRQ_B_BIT] &
                                      ~clr[pwt_pkg::IRQ_B_BIT]) | ev_b;

        // one level interrupt from the enabled flags
        nx.irq = |(nx.flg & nx.msk);
    end

    // all state registered on every edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= ST_RST;
        end else begin
            st <= nx;
        end
    end

    // outputs straight from state flops
    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.wait_rq;
    assign irq = st.irq;
    assign pwm_out = st.pwm;
    assign cmp_a_evt = st.evt_a;
    assign cmp_b_evt = st.evt_b;

    // checks on the block's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_req_taken;
        req && st.bus == pwt_pkg::BUS_IDLE;
    endsequence

    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_bus_answer: assert property (s_req_taken |=> s_answer)
        else $error("bus request not answered after one cycle");

    a_flag_b_set: assert property (ev_b |=> st.flg[pwt_pkg::IRQ_B_BIT])
        else $error("compare b event did not set its flag");

    a_flag_b_hold: assert property (
        st.flg[pwt_pkg::IRQ_B_BIT] && !clr[pwt_pkg::IRQ_B_BIT]
        |=> st.flg[pwt_pkg::IRQ_B_BIT])
        else $error("compare b flag dropped without a one written");

    a_flag_a_set: assert property (ev_a |=> st.flg[pwt_pkg::IRQ_A_BIT])
        else $error("compare a event did not set its flag");

    a_flag_a_clear: assert property (
        $fell(st.flg[pwt_pkg::IRQ_A_BIT]) && !$past(sys_rst)
        |-> $past(clr[pwt_pkg::IRQ_A_BIT]))
        else $error("compare a flag cleared without a one written");

    a_irq_gate_a: assert property (
        st.flg[pwt_pkg::IRQ_A_BIT] && st.msk[pwt_pkg::IRQ_A_BIT] |-> irq)
        else $error("enabled compare a flag not on the interrupt");

    a_irq_gate_b: assert property (
        !(st.flg[pwt_pkg::IRQ_A_BIT] && st.msk[pwt_pkg::IRQ_A_BIT]) &&
        !(st.flg[pwt_pkg::IRQ_B_BIT] && st.msk[pwt_pkg::IRQ_B_BIT])
        |-> !irq)
        else $error("interrupt raised with no enabled flag");

    a_count_hold: assert property (
        !st.run && !wr_count && !wr_clr |=> $stable(st.count))
        else $error("counter moved while stopped");

    a_count_step: assert property (
        step && !hit_b && !wr_count && !wr_clr
        |=> st.count == $past(st.count) + 16'h1)
        else $error("counter did not advance on a tick");

    // a stopped timer makes no compare events
    a_run_gate: assert property (!st.run |=> !cmp_a_evt && !cmp_b_evt)
        else $error("compare event while the timer is stopped");

    a_irq_b_on: assert property (
        st.flg[pwt_pkg::IRQ_B_BIT] && st.msk[pwt_pkg::IRQ_B_BIT] |-> irq)
        else $error("enabled compare b flag not on the interrupt");

    a_flag_b_clear: assert property (
        $fell(st.flg[pwt_pkg::IRQ_B_BIT]) && !$past(sys_rst)
        |-> $past(clr[pwt_pkg::IRQ_B_BIT]))
        else $error("compare b flag cleared without a one written");

    a_flag_a_hold: assert property (
        st.flg[pwt_pkg::IRQ_A_BIT] && !clr[pwt_pkg::IRQ_A_BIT]
        |=> st.flg[pwt_pkg::IRQ_A_BIT])
        else $error("compare a flag dropped without a one written");

    a_tap_stored: assert property (
        wr_tap && avs_byteenable[0] |=> st.tap == $past(avs_writedata[3:0]))
        else $error("tap select write not stored");

endmodule

// >>> tb/pwt_timer_tb.sv
// self-checking bench of the pwm timer clock select, mask, flags and run control
`timescale 1ns/10ps
module pwt_timer_tb;
    logic clk;
    logic sys_rst;
    logic [17:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic pwm_out;
    logic cmp_a_evt;
    logic cmp_b_evt;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    int gap;
    logic [15:0] rd;

    pwt_timer u_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .irq(irq),
        .pwm_out(pwm_out),
        .cmp_a_evt(cmp_a_evt),
        .cmp_b_evt(cmp_b_evt)
    );

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // cuts a hang short once the cycle ceiling is reached
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end

    // prints the counts and the verdict, then stops
    task automatic summarize();
        $display("errors %0d, comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // compares one 16-bit result
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] data);
        int n;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {16'h0000, data};
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) begin
            err_total++;
            $display("Error at %0t: no answer on the register bus", $time);
        end
        rd = avs_readdata[15:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] data);
        bus(1'b1, idx, data);
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 16'h0000);
        chk(rd, exp);
    endtask

    // counts edges until compare b pulses, giving up after 1000
    task automatic wait_evt(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cmp_b_evt !== 1'b1 && n < 1000);
    endtask

    task automatic irq_chk(input logic exp);
        @(negedge clk);
        chk({15'h0000, irq}, {15'h0000, exp});
    endtask

    // main sequence
    initial begin
        sys_rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 18'h00000;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hf;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        // values after reset
        rdchk(pwt_pkg::IDX_CLK_SEL, 16'h0000);
        rdchk(pwt_pkg::IDX_IRQ_MASK, 16'h0000);
        rdchk(pwt_pkg::IDX_IRQ_FLAG, 16'h0000);
        irq_chk(1'b0);
        // reserved upper bits of the tap register read as zero
        wr(pwt_pkg::IDX_CLK_SEL, 16'hfffa);
        rdchk(pwt_pkg::IDX_CLK_SEL, 16'h000a);
        // counter holds while stopped, advances while running
        wr(pwt_pkg::IDX_CMP_B, 16'hffff);
        wr(pwt_pkg::IDX_COUNT, 16'h0005);
        wr(pwt_pkg::IDX_CLK_SEL, 16'h0000);
        repeat (10) @(posedge clk);
        rdchk(pwt_pkg::IDX_COUNT, 16'h0005);
        wr(pwt_pkg::IDX_CTRL, 16'h0001);
        repeat (10) @(posedge clk);
        wr(pwt_pkg::IDX_CTRL, 16'h0000);
        bus(1'b0, pwt_pkg::IDX_COUNT, 16'h0000);
        chk({15'h0000, rd > 16'h0005}, 16'h0001);
        // period 0 makes every tick an event, so the event spacing is the tap
        wr(pwt_pkg::IDX_CMP_B, 16'h0000);
        wr(pwt_pkg::IDX_CMP_A, 16'h0000);
        // run together with the reset strobe, which reads back as zero
        wr(pwt_pkg::IDX_CTRL, 16'h0003);
        rdchk(pwt_pkg::IDX_CTRL, 16'h0001);
        rdchk(pwt_pkg::IDX_COUNT, 16'h0000);
        for (int t = 0; t < 5; t++) begin
            wr(pwt_pkg::IDX_CLK_SEL, 16'(t));
            wait_evt(gap);
            wait_evt(gap);
            wait_evt(gap);
            wait_evt(gap);
            chk(16'(gap), 16'(1 << t));
        end
        // the reserved tap never ticks
        wr(pwt_pkg::IDX_CLK_SEL, 16'h000f);
        repeat (5) @(posedge clk);
        wait_evt(gap);
        chk(16'(gap), 16'h03e8);
        // flags stay set and mask gates the interrupt line
        wr(pwt_pkg::IDX_CTRL, 16'h0000);
        rdchk(pwt_pkg::IDX_IRQ_FLAG, 16'h0003);
        irq_chk(1'b0);
        wr(pwt_pkg::IDX_IRQ_FLAG, 16'h0000);
        rdchk(pwt_pkg::IDX_IRQ_FLAG, 16'h0003);
        wr(pwt_pkg::IDX_IRQ_MASK, 16'h0002);
        irq_chk(1'b1);
        wr(pwt_pkg::IDX_IRQ_FLAG, 16'h0002);
        rdchk(pwt_pkg::IDX_IRQ_FLAG, 16'h0001);
        irq_chk(1'b0);
        wr(pwt_pkg::IDX_IRQ_MASK, 16'h0001);
        rdchk(pwt_pkg::IDX_IRQ_MASK, 16'h0001);
        irq_chk(1'b1);
        wr(pwt_pkg::IDX_IRQ_FLAG, 16'h0001);
        rdchk(pwt_pkg::IDX_IRQ_FLAG, 16'h0000);
        irq_chk(1'b0);
        // period of four steps: pwm rises on compare b, falls on compare a
        wr(pwt_pkg::IDX_CMP_A, 16'h0001);
        wr(pwt_pkg::IDX_CMP_B, 16'h0003);
        wr(pwt_pkg::IDX_CLK_SEL, 16'h0000);
        wr(pwt_pkg::IDX_CTRL, 16'h0003);
        wait_evt(gap);
        wait_evt(gap);
        chk(16'(gap), 16'h0004);
        @(negedge clk);
        chk({13'h0000, pwm_out, cmp_a_evt, cmp_b_evt}, 16'h0004);
        @(negedge clk);
        chk({13'h0000, pwm_out, cmp_a_evt, cmp_b_evt}, 16'h0002);
        rdchk(pwt_pkg::IDX_IRQ_FLAG, 16'h0003);
        irq_chk(1'b1);
        summarize();
    end
endmodule
